// ===== dv/mac_address_hash_filter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mac_address_hash_filter_tb_top;
  import mahf_pkg::*;
  // Compare and count; mismatches print at once
  `define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
  logic clk_i, rst_n_i;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ee_present, ee_done, acc, rej;
  logic [1:0] bresp, rresp, rsp;
  mahf_ee_byte_t ee_byte;
  mahf_rx_addr_t rx_addr;
  int n_fail, checked;
  logic [5:0] hi;
  logic [31:0] hu, hl;
  // Station address as loaded, then as rewritten by the host
  localparam logic [47:0] UNI = 48'h1234_5678_9abc;
  localparam logic [47:0] UNI2 = 48'h0211_2233_4455;
  localparam logic [47:0] GRP = 48'h0100_5e00_0001;
  mahf_filter u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_awaddr_i(awaddr),
    .s_awvalid_i(awvalid), .s_awready_o(awready), .s_wdata_i(wdata),
    .s_wstrb_i(4'hf), .s_wvalid_i(wvalid), .s_wready_o(wready),
    .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
    .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready),
    .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid),
    .s_rready_i(rready), .ee_present_i(ee_present), .ee_done_i(ee_done),
    .ee_byte_i(ee_byte), .rx_addr_i(rx_addr), .rx_accept_o(acc),
    .rx_reject_o(rej));
  mahf_phy_model u_phy (.clk_i(clk_i), .rx_o(rx_addr));
  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Verdict and end of run
  task automatic stop_test;
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    #5000000;
    n_fail++;
    stop_test;
  end
  // Group hash index: reflected bytes into msb-first CRC, top six bits
  function automatic logic [5:0] hidx(input logic [47:0] d);
    logic [31:0] c;
    logic b;
    c = 32'hffff_ffff;
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 8; j++) begin
        b = d[40 - 8 * i + j] ^ c[31];
        c = {c[30:0], 1'b0} ^ (b ? 32'h04c1_1db7 : 32'h0000_0000);
      end
    end
    return c[31:26];
  endfunction
  // Register write: address and data offered together, held until taken
  task automatic wr(input logic [3:0] i, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    awaddr <= {i, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    r = bresp;
    bready <= 1'b0;
    if (n >= 100) begin
      n_fail++;
      stop_test;
    end
  endtask
  // Register read with data and response compared
  task automatic rdc(input logic [3:0] i, input logic [31:0] e,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_i);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    rready <= 1'b0;
    if (n >= 100) begin
      n_fail++;
      stop_test;
    end
    `CHK(rdata, e)
    `CHK(rresp, er)
  endtask
  // Offer a frame, expect exactly one verdict pulse a cycle later
  task automatic rxc(input logic [47:0] d, input logic e);
    u_phy.send(d);
    #1;
    `CHK({acc, rej}, {e, ~e})
  endtask
  // Serial memory bytes 1..6 in wire order, then the controller is done
  task automatic ee_load(input logic [47:0] a);
    for (int k = 1; k <= 6; k++) begin
      @(posedge clk_i);
      ee_byte <= {1'b1, k[2:0], a[55 - 8 * k -: 8]};
    end
    @(posedge clk_i);
    ee_byte.valid <= 1'b0;
    ee_done <= 1'b1;
  endtask
  // Main sequence
  initial begin
    {rst_n_i, awvalid, wvalid, bready, arvalid, rready, ee_done} = '0;
    {awaddr, araddr, wdata, ee_byte} = '0;
    ee_present = 1'b1;
    n_fail = 0;
    checked = 0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdc(MAHF_IDX_ADDR_UPPER, 32'h0000_ffff, MAHF_RESP_OKAY);
    rdc(MAHF_IDX_HASH_UPPER, 32'h0000_0000, MAHF_RESP_OKAY);
    rdc(MAHF_IDX_HASH_LOWER, 32'h0000_0000, MAHF_RESP_OKAY);
    rdc(4'h7, 32'h0000_0000, MAHF_RESP_SLVERR);
    wr(4'h7, 32'h0000_0001, rsp);
    `CHK(rsp, MAHF_RESP_SLVERR)
    wr(MAHF_IDX_ADDR_LOWER, 32'h0000_0000, rsp);
    `CHK(rsp, MAHF_RESP_OKAY)
    rdc(MAHF_IDX_ADDR_LOWER, 32'h0fff_ffff, MAHF_RESP_OKAY);
    ee_load(UNI);
    rdc(MAHF_IDX_ADDR_LOWER, 32'h7856_3412, MAHF_RESP_OKAY);
    rdc(MAHF_IDX_ADDR_UPPER, 32'h0000_bc9a, MAHF_RESP_OKAY);
    rdc(MAHF_IDX_STATUS, 32'h0000_0007, MAHF_RESP_OKAY);
    rxc(UNI, 1'b0);
    wr(MAHF_IDX_CTRL, 32'h0000_0004, rsp);
    rxc(UNI, 1'b1);
    rxc(48'hbc9a_7856_3412, 1'b0);
    wr(MAHF_IDX_ADDR_LOWER, 32'h3322_1102, rsp);
    wr(MAHF_IDX_ADDR_UPPER, 32'h0000_5544, rsp);
    rdc(MAHF_IDX_ADDR_LOWER, 32'h3322_1102, MAHF_RESP_OKAY);
    rdc(MAHF_IDX_ADDR_UPPER, 32'h0000_5544, MAHF_RESP_OKAY);
    rxc(UNI2, 1'b1);
    // One hash bit set, in the register the index top bit names
    hi = hidx(GRP);
    hu = hi[5] ? (32'h0000_0001 << hi[4:0]) : 32'h0000_0000;
    hl = hi[5] ? 32'h0000_0000 : (32'h0000_0001 << hi[4:0]);
    rxc(GRP, 1'b0);
    wr(MAHF_IDX_HASH_UPPER, hu, rsp);
    wr(MAHF_IDX_HASH_LOWER, hl, rsp);
    rdc(MAHF_IDX_HASH_UPPER, hu, MAHF_RESP_OKAY);
    rdc(MAHF_IDX_HASH_LOWER, hl, MAHF_RESP_OKAY);
    rxc(GRP, 1'b1);
    // Same bit position in the other register must not match
    wr(MAHF_IDX_HASH_UPPER, hl, rsp);
    wr(MAHF_IDX_HASH_LOWER, hu, rsp);
    rxc(GRP, 1'b0);
    wr(MAHF_IDX_CTRL, 32'h0008_0004, rsp);
    rxc(GRP, 1'b1);
    wr(MAHF_IDX_CTRL, 32'h0008_0000, rsp);
    rxc(GRP, 1'b0);
    // Second power-on with no programmed part: its bytes must be ignored
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    ee_present <= 1'b0;
    ee_done <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    ee_load(UNI2);
    rdc(MAHF_IDX_ADDR_LOWER, 32'h0fff_ffff, MAHF_RESP_OKAY);
    rdc(MAHF_IDX_ADDR_UPPER, 32'h0000_ffff, MAHF_RESP_OKAY);
    rdc(MAHF_IDX_STATUS, 32'h0000_0003, MAHF_RESP_OKAY);
    rxc(UNI2, 1'b0);
    stop_test;
  end
endmodule
`default_nettype wire

// ===== dv/mahf_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
// Receive path stand-in: offers one destination address per frame
module mahf_phy_model
  import mahf_pkg::*;
(
  input wire logic clk_i,
  output var mahf_rx_addr_t rx_o
);
  // Quiet until the first frame
  initial rx_o = '0;
  // One-cycle valid pulse; released lines flip so no stale copy passes
  task automatic send(input logic [47:0] d);
    @(posedge clk_i);
    rx_o <= {1'b1, d};
    @(posedge clk_i);
    rx_o <= {1'b0, ~d};
  endtask
endmodule
`default_nettype wire

// ===== src/mahf_filter.sv
// Operation
// - Receive enable gates all frame acceptance
// - Upper address register holds bits 47:32
// - Lower address register holds bits 31:0
// - Address loads only from programmed EEPROM
// - EEPROM bytes 1-4 fill lower register
// - EEPROM bytes 5-6 fill upper register
// - First wire byte matches lower bits 7:0
// - Index MSB picks register, rest bit
// - Hash bit one accepts, zero rejects
// - Pass-all-group accepts every multicast frame while receive is enabled
// - Upper hash register holds upper 32 bits
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module mahf_filter
  import mahf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  // AXI4-Lite slave
  input wire logic [5:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [5:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // EEPROM controller side, same clock
  input wire logic ee_present_i,
  input wire logic ee_done_i,
  input wire mahf_ee_byte_t ee_byte_i,
  // Received destination address from PHY receive path
  input wire mahf_rx_addr_t rx_addr_i,
  output logic rx_accept_o,
  output logic rx_reject_o
);

  // Register storage
  logic [31:0] ctrl_r;
  logic [15:0] addr_upper_r;
  logic [31:0] addr_lower_r;
  logic [31:0] hash_upper_r;
  logic [31:0] hash_lower_r;
  mahf_ld_state_t ld_state_r;
  logic load_ok_r;

  // Bus holding state
  logic aw_held_r;
  logic w_held_r;
  logic [5:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  // CRC over the 48-bit address, LSB of each byte first on the wire
  function automatic logic [31:0] mahf_crc48(input logic [47:0] a);
    logic [31:0] c;
    logic fb;
    c = MAHF_CRC_INIT;
    for (int i = 0; i < 48; i++) begin
      fb = c[31] ^ a[47 - 8 * (i / 8) - 7 + (i % 8)];
      c = {c[30:0], 1'b0};
      if (fb) begin
        c = c ^ MAHF_CRC_POLY;
      end
    end
    return c;
  endfunction

  // Byte lane merge for writes
  function automatic logic [31:0] mahf_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        m[8 * b +: 8] = nw[8 * b +: 8];
      end
    end
    return m;
  endfunction

  // Write happens once both address and data are held and no response waits
  logic wr_fire;
  logic [3:0] wr_idx;
  assign wr_fire = aw_held_r && w_held_r && !s_bvalid_o;
  assign wr_idx = awaddr_r[5:2];
  assign s_awready_o = !aw_held_r;
  assign s_wready_o = !w_held_r;
  assign s_arready_o = !s_rvalid_o;

  // Address and data capture, either order
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 6'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_awaddr_i;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_held_r <= 1'b1;
        wdata_r <= s_wdata_i;
        wstrb_r <= s_wstrb_i;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Write response; unmapped index answers SLVERR
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_bvalid_o <= 1'b0;
      s_bresp_o <= MAHF_RESP_OKAY;
    end else if (wr_fire) begin
      s_bvalid_o <= 1'b1;
      case (wr_idx)
        MAHF_IDX_CTRL, MAHF_IDX_ADDR_UPPER, MAHF_IDX_ADDR_LOWER,
        MAHF_IDX_HASH_UPPER, MAHF_IDX_HASH_LOWER: begin
          s_bresp_o <= MAHF_RESP_OKAY;
        end
        default: begin
          s_bresp_o <= MAHF_RESP_SLVERR;
        end
      endcase
    end else if (s_bready_i) begin
      s_bvalid_o <= 1'b0;
    end
  end

  // Power-on loader: waits for the EEPROM controller to finish
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ld_state_r <= MAHF_LD_IDLE;
      load_ok_r <= 1'b0;
    end else begin
      case (ld_state_r)
        MAHF_LD_IDLE: begin
          ld_state_r <= MAHF_LD_FETCH;
          load_ok_r <= ee_present_i;
        end
        MAHF_LD_FETCH: begin
          if (ee_done_i) begin
            ld_state_r <= MAHF_LD_DONE;
          end
        end
        MAHF_LD_DONE: begin
          ld_state_r <= MAHF_LD_DONE;
        end
        default: begin
          ld_state_r <= MAHF_LD_IDLE;
        end
      endcase
    end
  end

  logic ld_take;
  logic host_ok;
  // EEPROM bytes only count while loading and a programmed part is seen
  assign ld_take = (ld_state_r == MAHF_LD_FETCH) && load_ok_r &&
                   ee_byte_i.valid;
  // Host writes to the address are dropped until initialization finishes
  assign host_ok = (ld_state_r == MAHF_LD_DONE) && wr_fire;
  logic [31:0] upper_merged;
  // Merge against the 16 live bits; the reserved half is never stored
  assign upper_merged = mahf_merge({16'h0000, addr_upper_r}, wdata_r,
                                   wstrb_r);

  // Station address registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_upper_r <= MAHF_RST_ADDR_UPPER[15:0];
      addr_lower_r <= MAHF_RST_ADDR_LOWER;
    end else if (ld_take) begin
      if (ee_byte_i.loc >= MAHF_EE_FIRST &&
          ee_byte_i.loc <= MAHF_EE_LOWER_LAST) begin
        // Byte n lands in lane n-1
        addr_lower_r[8 * (ee_byte_i.loc - MAHF_EE_FIRST) +: 8] <=
          ee_byte_i.data;
      end else if (ee_byte_i.loc == MAHF_EE_UPPER_FIRST) begin
        addr_upper_r[7:0] <= ee_byte_i.data;
      end else if (ee_byte_i.loc == MAHF_EE_LAST) begin
        addr_upper_r[15:8] <= ee_byte_i.data;
      end
    end else if (host_ok && wr_idx == MAHF_IDX_ADDR_UPPER) begin
      addr_upper_r <= upper_merged[15:0];
    end else if (host_ok && wr_idx == MAHF_IDX_ADDR_LOWER) begin
      addr_lower_r <= mahf_merge(addr_lower_r, wdata_r, wstrb_r);
    end
  end

  // Control and hash table registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= MAHF_RST_CTRL;
      hash_upper_r <= MAHF_RST_HASH;
      hash_lower_r <= MAHF_RST_HASH;
    end else if (wr_fire) begin
      case (wr_idx)
        MAHF_IDX_CTRL: begin
          ctrl_r <= mahf_merge(ctrl_r, wdata_r, wstrb_r);
        end
        MAHF_IDX_HASH_UPPER: begin
          hash_upper_r <= mahf_merge(hash_upper_r, wdata_r, wstrb_r);
        end
        MAHF_IDX_HASH_LOWER: begin
          hash_lower_r <= mahf_merge(hash_lower_r, wdata_r, wstrb_r);
        end
        default: begin
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  // Read channel: one cycle after the address is taken
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_rvalid_o <= 1'b0;
      s_rdata_o <= 32'h0000_0000;
      s_rresp_o <= MAHF_RESP_OKAY;
    end else if (s_arvalid_i && s_arready_o) begin
      s_rvalid_o <= 1'b1;
      s_rresp_o <= MAHF_RESP_OKAY;
      case (s_araddr_i[5:2])
        MAHF_IDX_CTRL: s_rdata_o <= ctrl_r;
        MAHF_IDX_ADDR_UPPER: s_rdata_o <= {16'h0000, addr_upper_r};
        MAHF_IDX_ADDR_LOWER: s_rdata_o <= addr_lower_r;
        MAHF_IDX_HASH_UPPER: s_rdata_o <= hash_upper_r;
        MAHF_IDX_HASH_LOWER: s_rdata_o <= hash_lower_r;
        MAHF_IDX_STATUS: s_rdata_o <= {29'h0000_0000, load_ok_r,
                                       ld_state_r};
        default: begin
          s_rdata_o <= 32'h0000_0000;
          s_rresp_o <= MAHF_RESP_SLVERR;
        end
      endcase
    end else if (s_rready_i) begin
      s_rvalid_o <= 1'b0;
    end
  end

  // Filter decision
  logic [47:0] own_wire;
  logic [31:0] rx_crc;
  logic [5:0] hash_idx;
  logic hash_hit;
  logic is_group;
  logic addr_ok;
  logic rx_en;
  // Station address in wire order, first byte in bits 47:40
  assign own_wire = {addr_lower_r[7:0], addr_lower_r[15:8],
                     addr_lower_r[23:16], addr_lower_r[31:24],
                     addr_upper_r[7:0], addr_upper_r[15:8]};
  assign rx_crc = mahf_crc48(rx_addr_i.dest);
  assign hash_idx = rx_crc[31:26];
  // Index MSB selects the upper half of the table
  assign hash_hit = hash_idx[5] ? hash_upper_r[hash_idx[4:0]]
                                : hash_lower_r[hash_idx[4:0]];
  // Group bit is first bit on the wire, LSB of first byte
  assign is_group = rx_addr_i.dest[40];
  assign rx_en = ctrl_r[MAHF_CTRL_RX_ENABLE_BIT];
  assign addr_ok = is_group ? (ctrl_r[MAHF_CTRL_PASS_GROUP_BIT] || hash_hit)
                            : (rx_addr_i.dest == own_wire);

  // Verdict registered one cycle after the address is offered
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_accept_o <= 1'b0;
      rx_reject_o <= 1'b0;
    end else begin
      rx_accept_o <= rx_addr_i.valid && rx_en && addr_ok;
      rx_reject_o <= rx_addr_i.valid && !(rx_en && addr_ok);
    end
  end

  a_rx_disabled: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) !$past(rx_en) |-> !rx_accept_o)
    else $error("accept while disabled");
  a_upper_clear: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) s_rvalid_o &&
    $past(s_araddr_i[5:2] == MAHF_IDX_ADDR_UPPER && s_arvalid_i &&
    s_arready_o) |-> s_rdata_o[31:16] == 16'h0000)
    else $error("upper reserved bits set");
  a_lower_load: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) ld_take && ee_byte_i.loc == MAHF_EE_FIRST |=>
    addr_lower_r[7:0] == $past(ee_byte_i.data))
    else $error("first EEPROM byte lost");
  a_upper_load: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) ld_take && ee_byte_i.loc == MAHF_EE_LAST |=>
    addr_upper_r[15:8] == $past(ee_byte_i.data))
    else $error("sixth EEPROM byte lost");
  a_no_blank_load: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) !load_ok_r && !wr_fire |=> $stable(addr_lower_r))
    else $error("address changed without source");
  a_pass_group: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) rx_addr_i.valid && rx_en && is_group &&
    ctrl_r[MAHF_CTRL_PASS_GROUP_BIT] |=> rx_accept_o)
    else $error("group frame dropped");
  a_hash_reject: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) rx_addr_i.valid && is_group &&
    !ctrl_r[MAHF_CTRL_PASS_GROUP_BIT] && !hash_hit |=> rx_reject_o)
    else $error("hash miss accepted");
  // Checked against the table registers, not against the mux output
  a_hash_upper: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) rx_addr_i.valid && rx_en && is_group &&
    !ctrl_r[MAHF_CTRL_PASS_GROUP_BIT] && hash_idx[5] |=>
    rx_accept_o == $past(hash_upper_r[hash_idx[4:0]]))
    else $error("upper hash bit ignored");
  a_hash_lower: assert property (@(posedge clk_i)
    disable iff (!rst_n_i) rx_addr_i.valid && rx_en && is_group &&
    !ctrl_r[MAHF_CTRL_PASS_GROUP_BIT] && !hash_idx[5] |=>
    rx_accept_o == $past(hash_lower_r[hash_idx[4:0]]))
    else $error("lower hash bit ignored");

endmodule
`default_nettype wire

// ===== src/mahf_pkg.sv
package mahf_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [3:0] MAHF_IDX_CTRL = 4'h1;
  localparam logic [3:0] MAHF_IDX_ADDR_UPPER = 4'h2;
  localparam logic [3:0] MAHF_IDX_ADDR_LOWER = 4'h3;
  localparam logic [3:0] MAHF_IDX_HASH_UPPER = 4'h4;
  localparam logic [3:0] MAHF_IDX_HASH_LOWER = 4'h5;
  localparam logic [3:0] MAHF_IDX_STATUS = 4'h9;

  // Reset values
  localparam logic [31:0] MAHF_RST_ADDR_UPPER = 32'h0000_ffff;
  localparam logic [31:0] MAHF_RST_ADDR_LOWER = 32'h0fff_ffff;
  localparam logic [31:0] MAHF_RST_HASH = 32'h0000_0000;
  localparam logic [31:0] MAHF_RST_CTRL = 32'h0000_0000;

  // Control register field positions
  localparam int MAHF_CTRL_RX_ENABLE_BIT = 2;
  localparam int MAHF_CTRL_PASS_GROUP_BIT = 19;

  // EEPROM byte locations of the station address
  localparam logic [2:0] MAHF_EE_FIRST = 3'h1;
  localparam logic [2:0] MAHF_EE_LAST = 3'h6;
  // Last byte of the lower register, first byte of the upper one
  localparam logic [2:0] MAHF_EE_LOWER_LAST = 3'h4;
  localparam logic [2:0] MAHF_EE_UPPER_FIRST = 3'h5;

  // AXI responses
  localparam logic [1:0] MAHF_RESP_OKAY = 2'h0;
  localparam logic [1:0] MAHF_RESP_SLVERR = 2'h2;

  // CRC-32 constants
  localparam logic [31:0] MAHF_CRC_POLY = 32'h04c1_1db7;
  localparam logic [31:0] MAHF_CRC_INIT = 32'hffff_ffff;

  // Loader states, Gray along the path
  typedef enum logic [1:0] {
    MAHF_LD_IDLE = 2'b00,
    MAHF_LD_FETCH = 2'b01,
    MAHF_LD_DONE = 2'b11
  } mahf_ld_state_t;

  // EEPROM byte stream from the serial EEPROM controller
  typedef struct packed {
    logic valid;
    logic [2:0] loc;
    logic [7:0] data;
  } mahf_ee_byte_t;

  // Received destination address offered for filtering
  typedef struct packed {
    logic valid;
    logic [47:0] dest;
  } mahf_rx_addr_t;

endpackage
